// *** sms_status_reg.sv ***
// supply monitor status and configuration register with its serial access
`timescale 1ns/1ps
module sms_status_reg
   import sms_pkg::*;
#(
   parameter int unsigned FILTER_CYCLES = UV_FILTER_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ext_reset_n_in,
   input  wire logic vdd_overvoltage_in,
   input  wire logic vdd_undervoltage_in,
   input  wire logic diag_error_in,
   input  wire logic stage_overtemp_in,
   input  wire logic stage_enable_pin_in,
   output logic      stage_enable_pin_out,
   output logic      stage_enable_pin_oe_out,
   input  wire logic spi_clk_in,
   input  wire logic spi_cs_n_in,
   input  wire logic spi_mosi_in,
   output logic      spi_miso_out,
   output logic      spi_miso_oe_out,
   output logic      diag_clear_out,
   output logic      threshold_test_disable_out,
   output logic      threshold_test_select_out
);

   // ********************************************************
   // parameter check
   // ********************************************************
   initial begin
      if (FILTER_CYCLES < 1 || FILTER_CYCLES > 65535)
         $error("sms_status_reg: FILTER_CYCLES out of range");
   end

   // ********************************************************
   // synchronised pins and comparators
   // ********************************************************
   logic [3:0] pins_s;
   logic       ext_reset_n_s;
   logic       ov_live;
   logic       uv_live;
   logic       pin_level;

   // reset pin and stage enable pin idle high, comparators idle low
   sms_sync #(.WIDTH(4), .RESET_VALUE(4'h9)) u_pin_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .async_in ({ext_reset_n_in, vdd_overvoltage_in, vdd_undervoltage_in, stage_enable_pin_in}),
      .sync_out (pins_s)
   );

   assign ext_reset_n_s = pins_s[3];
   assign ov_live       = pins_s[2];
   assign uv_live       = pins_s[1];
   assign pin_level     = pins_s[0];

   // ********************************************************
   // serial access
   // ********************************************************
   logic [7:0] instr;
   logic [7:0] wdata;
   logic       frame_done;
   logic [7:0] read_value;
   logic       wr_cmd;
   logic       clr_cmd;

   sms_spi_slave u_spi (
      .clk_in         (clk_in),
      .rst_n_in       (rst_n_in),
      .sclk_in        (spi_clk_in),
      .cs_n_in        (spi_cs_n_in),
      .mosi_in        (spi_mosi_in),
      .tx_byte_in     (read_value),
      .instr_out      (instr),
      .data_out       (wdata),
      .frame_done_out (frame_done),
      .miso_out       (spi_miso_out),
      .miso_oe_out    (spi_miso_oe_out)
   );

   // other instruction codes belong to neighbouring registers and are ignored here
   assign wr_cmd  = frame_done && (instr == INSTR_STATUS_WRITE);
   assign clr_cmd = frame_done && (instr == INSTR_DIAG_CLEAR);

   // ********************************************************
   // configuration bits 5..7
   // ********************************************************
   logic ov_latch_en_q;
   logic thr_select_q;
   logic thr_disable_q;

   // the undervoltage reset returns the configuration to its defaults;
   // the reset pin leaves it alone so latching keeps running during it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || uv_live) begin
         ov_latch_en_q <= RST_OV_LATCH_EN;
         thr_select_q  <= RST_THR_SELECT;
         thr_disable_q <= RST_THR_DISABLE;
      end else if (wr_cmd) begin
         ov_latch_en_q <= wdata[BIT_OV_LATCH_EN];
         thr_select_q  <= wdata[BIT_THR_SELECT];
         thr_disable_q <= wdata[BIT_THR_DISABLE];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         threshold_test_disable_out <= RST_THR_DISABLE;
         threshold_test_select_out  <= RST_THR_SELECT;
      end else begin
         threshold_test_disable_out <= thr_disable_q;
         threshold_test_select_out  <= thr_select_q;
      end
   end

   // ********************************************************
   // overvoltage latch
   // ********************************************************
   logic ov_held_q;
   logic ov_status;

   // ext_reset_n_s deliberately takes no part here
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || uv_live) begin
         ov_held_q <= 1'b0;
      end else if (!ov_latch_en_q || (wr_cmd && !wdata[BIT_OV_LATCH_EN])) begin
         ov_held_q <= 1'b0;
      end else if (ov_live) begin
         ov_held_q <= 1'b1;
      end
   end

   assign ov_status = ~(ov_live | ov_held_q);

   // ********************************************************
   // diagnostic summary flags
   // ********************************************************
   logic common_otemp_q;
   logic common_error_q;

   // an overtemperature arriving with a clear wins, so no event is lost
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         common_otemp_q <= RST_COMMON_OTEMP;
      end else if (stage_overtemp_in) begin
         common_otemp_q <= 1'b0;
      end else if (clr_cmd || !ext_reset_n_s || uv_live) begin
         common_otemp_q <= RST_COMMON_OTEMP;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         common_error_q <= 1'b1;
      end else begin
         common_error_q <= ~diag_error_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         diag_clear_out <= 1'b0;
      end else begin
         diag_clear_out <= clr_cmd;
      end
   end

   // ********************************************************
   // stage enable pin drive
   // ********************************************************
   logic [15:0] uv_filter_q;
   logic        uv_hold;

   // after undervoltage the pin is released only once the supply has been
   // good for the filter time; a held overvoltage keeps it low until cleared
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         uv_filter_q <= 16'h0000;
      end else if (uv_live) begin
         uv_filter_q <= 16'(FILTER_CYCLES);
      end else if (uv_filter_q != 16'h0000) begin
         uv_filter_q <= uv_filter_q - 16'h0001;
      end
   end

   assign uv_hold = uv_live || (uv_filter_q != 16'h0000);

   // open drain: only ever pulls low
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         stage_enable_pin_out    <= 1'b0;
         stage_enable_pin_oe_out <= 1'b0;
      end else begin
         stage_enable_pin_out    <= 1'b0;
         stage_enable_pin_oe_out <= uv_hold || !ov_status;
      end
   end

   // ********************************************************
   // read back value
   // ********************************************************
   always_comb begin
      read_value                   = 8'h00;
      read_value[BIT_OV_STATUS]    = ov_status;
      read_value[BIT_UV_STATUS]    = ~uv_live;
      read_value[BIT_PIN_LEVEL]    = pin_level;
      read_value[BIT_COMMON_ERROR] = common_error_q;
      read_value[BIT_COMMON_OTEMP] = common_otemp_q;
      read_value[BIT_OV_LATCH_EN]  = ov_latch_en_q;
      read_value[BIT_THR_SELECT]   = thr_select_q;
      read_value[BIT_THR_DISABLE]  = thr_disable_q;
   end

endmodule : sms_status_reg

// *** sms_pkg.sv ***
// constants shared by the supply monitor status/config register files
package sms_pkg;

   // ********************************************************
   // register bit positions
   // ********************************************************
   localparam int unsigned BIT_OV_STATUS     = 0;
   localparam int unsigned BIT_UV_STATUS     = 1;
   localparam int unsigned BIT_PIN_LEVEL     = 2;
   localparam int unsigned BIT_COMMON_ERROR  = 3;
   localparam int unsigned BIT_COMMON_OTEMP  = 4;
   localparam int unsigned BIT_OV_LATCH_EN   = 5;
   localparam int unsigned BIT_THR_SELECT    = 6;
   localparam int unsigned BIT_THR_DISABLE   = 7;

   // ********************************************************
   // reset values of the stored bits
   // ********************************************************
   localparam logic RST_OV_LATCH_EN  = 1'b1;
   localparam logic RST_THR_SELECT   = 1'b1;
   localparam logic RST_THR_DISABLE  = 1'b1;
   localparam logic RST_COMMON_OTEMP = 1'b1;

   // ********************************************************
   // serial frame: one instruction byte, one data byte
   // ********************************************************
   localparam int unsigned BYTE_BITS  = 8;
   localparam int unsigned FRAME_BITS = 16;
   localparam logic [7:0]  INSTR_STATUS_WRITE = 8'hA5;
   localparam logic [7:0]  INSTR_STATUS_READ  = 8'h5A;
   localparam logic [7:0]  INSTR_DIAG_CLEAR   = 8'h3C;

   // ********************************************************
   // timing
   // ********************************************************
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned UV_FILTER_NS    = 10_000;
   localparam int unsigned UV_FILTER_CYCLES =
      (UV_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage : sms_pkg

// *** sms_sync.sv ***
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sms_sync #(
   parameter int unsigned   WIDTH       = 1,
   // each bit resets to its pin's idle level so no false edge follows reset
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   initial begin
      if (WIDTH < 1) $error("sms_sync: WIDTH must be at least 1");
   end

   // first stage is read only by the second stage
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         meta_q   <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : sms_sync

// *** sms_spi_slave.sv ***
// serial slave: samples the link clock, shifts a 16-bit instruction/data frame
`timescale 1ns/1ps
module sms_spi_slave
   import sms_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       sclk_in,
   input  wire logic       cs_n_in,
   input  wire logic       mosi_in,
   input  wire logic [7:0] tx_byte_in,
   output logic      [7:0] instr_out,
   output logic      [7:0] data_out,
   output logic            frame_done_out,
   output logic            miso_out,
   output logic            miso_oe_out
);
   logic [2:0]  pins_s;
   logic        sclk_d1_q;
   logic        cs_d1_q;
   logic [15:0] rx_q;
   logic [7:0]  tx_q;
   logic [4:0]  count_q;
   logic        rise;
   logic        fall;
   logic        cs_rise;
   logic        active;

   // chip select idles high: a deselected link must not look selected after reset
   sms_sync #(.WIDTH(3), .RESET_VALUE(3'h2)) u_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .async_in ({sclk_in, cs_n_in, mosi_in}),
      .sync_out (pins_s)
   );

   assign active  = ~pins_s[1];
   assign rise    = active & pins_s[2] & ~sclk_d1_q;
   assign fall    = active & ~pins_s[2] & sclk_d1_q;
   assign cs_rise = pins_s[1] & ~cs_d1_q;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sclk_d1_q <= 1'b0;
         cs_d1_q   <= 1'b1;
      end else begin
         sclk_d1_q <= pins_s[2];
         cs_d1_q   <= pins_s[1];
      end
   end

   // ********************************************************
   // receive: msb first on rising link clock edges
   // ********************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rx_q    <= 16'h0000;
         count_q <= 5'h00;
      end else if (!active) begin
         count_q <= 5'h00;
      end else if (rise) begin
         rx_q <= {rx_q[14:0], pins_s[0]};
         // extra clocks saturate the count so the frame is rejected
         if (count_q <= 5'(FRAME_BITS)) count_q <= count_q + 5'h01;
      end
   end

   // only an exact 16-clock frame is executed, at chip-select release
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         frame_done_out <= 1'b0;
         instr_out      <= 8'h00;
         data_out       <= 8'h00;
      end else begin
         frame_done_out <= cs_rise && (count_q == 5'(FRAME_BITS));
         if (cs_rise && (count_q == 5'(FRAME_BITS))) begin
            instr_out <= rx_q[15:8];
            data_out  <= rx_q[7:0];
         end
      end
   end

   // ********************************************************
   // transmit: answer byte follows the instruction byte
   // ********************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_q        <= 8'h00;
         miso_out    <= 1'b0;
         miso_oe_out <= 1'b0;
      end else begin
         miso_oe_out <= active;
         if (!active) begin
            tx_q     <= 8'h00;
            miso_out <= 1'b0;
         end else if (rise && (count_q == 5'(BYTE_BITS - 1))) begin
            tx_q <= tx_byte_in;
         end else if (fall) begin
            miso_out <= tx_q[7];
            tx_q     <= {tx_q[6:0], 1'b0};
         end
      end
   end
endmodule : sms_spi_slave

// *** sms_status_reg_assertions.sv ***
// port-level checker for the supply monitor status/config register
`timescale 1ns/1ps
module sms_status_reg_chk #(
   parameter int unsigned FILTER_CYCLES = 4
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ext_reset_n_in,
   input wire logic vdd_overvoltage_in,
   input wire logic vdd_undervoltage_in,
   input wire logic diag_error_in,
   input wire logic stage_overtemp_in,
   input wire logic stage_enable_pin_in,
   input wire logic stage_enable_pin_out,
   input wire logic stage_enable_pin_oe_out,
   input wire logic spi_clk_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_mosi_in,
   input wire logic spi_miso_out,
   input wire logic spi_miso_oe_out,
   input wire logic diag_clear_out,
   input wire logic threshold_test_disable_out,
   input wire logic threshold_test_select_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ********************************************************
   // port relations
   // ********************************************************
   reset_vals_a: assert property (disable iff (1'b0)
      !rst_n_in |=> threshold_test_disable_out && threshold_test_select_out && !diag_clear_out)
      else $error("reset values wrong");
   clear_pulse_a: assert property (diag_clear_out |=> !diag_clear_out)
      else $error("diag clear longer than one cycle");
   clear_after_frame_a: assert property (diag_clear_out |-> $past(spi_cs_n_in, 2))
      else $error("diag clear without a finished frame");
   config_by_frame_a: assert property (!$stable(threshold_test_disable_out) |-> spi_cs_n_in)
      else $error("threshold disable changed inside a frame");
   uv_config_a: assert property ((vdd_undervoltage_in) [*4] |=>
      threshold_test_disable_out && threshold_test_select_out)
      else $error("undervoltage did not restore config");
   ov_pin_a: assert property ((vdd_overvoltage_in) [*4] |=> stage_enable_pin_oe_out)
      else $error("overvoltage did not pull the enable pin");
   uv_pin_a: assert property ((vdd_undervoltage_in) [*4] |=> stage_enable_pin_oe_out)
      else $error("undervoltage did not pull the enable pin");
   pin_release_a: assert property ($fell(stage_enable_pin_oe_out) |->
      !$past(vdd_overvoltage_in, 3) && !$past(vdd_undervoltage_in, 3))
      else $error("enable pin released during a fault");
   miso_on_a: assert property ((!spi_cs_n_in) [*4] |-> spi_miso_oe_out)
      else $error("miso not driven while selected");
   miso_off_a: assert property ((spi_cs_n_in) [*4] |-> !spi_miso_oe_out)
      else $error("miso driven while deselected");
   pin_low_a: assert property (!stage_enable_pin_out)
      else $error("enable pin driven high");
   diag_clear_c: cover property (diag_clear_out);
   ov_pin_c: cover property ($fell(stage_enable_pin_oe_out));
   thr_c: cover property ($fell(threshold_test_disable_out));
endmodule : sms_status_reg_chk
bind sms_status_reg sms_status_reg_chk #(.FILTER_CYCLES(FILTER_CYCLES)) u_chk (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .ext_reset_n_in(ext_reset_n_in),
   .vdd_overvoltage_in(vdd_overvoltage_in), .vdd_undervoltage_in(vdd_undervoltage_in),
   .diag_error_in(diag_error_in), .stage_overtemp_in(stage_overtemp_in),
   .stage_enable_pin_in(stage_enable_pin_in), .stage_enable_pin_out(stage_enable_pin_out),
   .stage_enable_pin_oe_out(stage_enable_pin_oe_out), .spi_clk_in(spi_clk_in),
   .spi_cs_n_in(spi_cs_n_in), .spi_mosi_in(spi_mosi_in), .spi_miso_out(spi_miso_out),
   .spi_miso_oe_out(spi_miso_oe_out), .diag_clear_out(diag_clear_out),
   .threshold_test_disable_out(threshold_test_disable_out),
   .threshold_test_select_out(threshold_test_select_out));

// *** sms_mcu_model.sv ***
// microcontroller model: serial master of the status/config register
`timescale 1ns/1ps
module sms_mcu_model (
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b1;
   end
   // mode 0, msb first; clock stands low between frames; first link clock edge is rising
   task automatic xfer(input logic [7:0] instr, input logic [7:0] data, input int nbits,
                       output logic [7:0] rdata);
      logic [15:0] frame;
      frame = {instr, data};
      rdata = 8'h00;
      cs_n_out = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         mosi_out = frame[15 - i];
         #80 sclk_out = 1'b1;
         if (i >= 8) rdata[15 - i] = miso_in;
         #80 sclk_out = 1'b0;
      end
      #80 cs_n_out = 1'b1;
      mosi_out = ~mosi_out; // released line shows no stale bit
      #200;
   endtask : xfer
endmodule : sms_mcu_model

// *** tb_top.sv ***
// self-checking bench for the supply monitor status/config register
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import sms_pkg::*;
   typedef struct packed {logic [7:0] w; logic ov; logic derr; logic [7:0] exp;} sms_row_t;
   logic     clk_in, rst_n_in, ext_rst_n, ov, uv, derr, otemp;
   logic     pin_out, pin_oe, sclk, cs_n, mosi, miso, miso_oe, dclr, thr_dis, thr_sel;
   wire      pin_lvl = ~pin_oe; // open-drain pin with pull-up
   int       num_errors = 0;
   int       tests_run = 0;
   sms_row_t rows [5] = '{'{8'h00, 1'b0, 1'b0, 8'h1F}, '{8'h40, 1'b0, 1'b1, 8'h57},
                          '{8'h80, 1'b1, 1'b0, 8'h9A}, '{8'h80, 1'b0, 1'b0, 8'h9F},
                          '{8'hE0, 1'b0, 1'b0, 8'hFF}};
   sms_status_reg #(.FILTER_CYCLES(4)) DUT (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .ext_reset_n_in(ext_rst_n), .vdd_overvoltage_in(ov),
      .vdd_undervoltage_in(uv), .diag_error_in(derr), .stage_overtemp_in(otemp),
      .stage_enable_pin_in(pin_lvl), .stage_enable_pin_out(pin_out), .stage_enable_pin_oe_out(pin_oe),
      .spi_clk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
      .spi_miso_oe_out(miso_oe), .diag_clear_out(dclr), .threshold_test_disable_out(thr_dis),
      .threshold_test_select_out(thr_sel));
   sms_mcu_model u_mcu (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask : cyc
   task automatic frame(input logic [7:0] ins, input logic [7:0] d, input int n);
      logic [7:0] r;
      u_mcu.xfer(ins, d, n, r);
   endtask : frame
   task automatic check_read(input logic [7:0] e, input logic [7:0] m, input string nm);
      logic [7:0] r;
      u_mcu.xfer(INSTR_STATUS_READ, 8'h00, 16, r);
      `CHK(nm, e & m, r & m)
      $display("test %s done", nm);
   endtask : check_read
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   initial begin
      #1_000_000;
      num_errors++;
      final_report();
   end
   initial begin
      {rst_n_in, ov, uv, derr, otemp} = '0;
      ext_rst_n = 1'b1;
      cyc(10);
      rst_n_in = 1'b1;
      cyc(5);
      check_read(8'hFF, 8'hFB, "reset");
      foreach (rows[i]) begin
         ov = rows[i].ov;
         derr = rows[i].derr;
         cyc(5);
         frame(INSTR_STATUS_WRITE, rows[i].w, 16);
         check_read(rows[i].exp, 8'hFF, "row");
         `CHK("thr", rows[i].w[7:6], {thr_dis, thr_sel})
      end
      // ov latch: held through the reset pin, cleared by latch enable 0 and by undervoltage
      ov = 1'b1;
      cyc(5);
      ov = 1'b0;
      cyc(10);
      check_read(8'hFA, 8'hFF, "ov hold");
      ext_rst_n = 1'b0;
      cyc(5);
      check_read(8'hFA, 8'hFF, "ov hold reset pin");
      ext_rst_n = 1'b1;
      frame(INSTR_STATUS_WRITE, 8'hE0, 16);
      check_read(8'hFA, 8'hFF, "ov hold write 1");
      frame(INSTR_STATUS_WRITE, 8'hC0, 16);
      check_read(8'hDF, 8'hFF, "ov latch off");
      frame(INSTR_STATUS_WRITE, 8'h20, 16);
      ext_rst_n = 1'b0;
      ov = 1'b1;
      cyc(5);
      ov = 1'b0;
      cyc(5);
      ext_rst_n = 1'b1;
      check_read(8'h3A, 8'hFF, "ov during reset pin");
      uv = 1'b1;
      cyc(10);
      check_read(8'h00, 8'h02, "uv live");
      uv = 1'b0;
      cyc(10);
      check_read(8'hFF, 8'hFF, "uv clears");
      // sticky overtemperature and its three clears
      for (int k = 0; k < 3; k++) begin
         otemp = 1'b1;
         cyc(3);
         otemp = 1'b0;
         cyc(3);
         check_read(8'hEF, 8'hFF, "otemp sticky");
         if (k == 0) frame(INSTR_DIAG_CLEAR, 8'h00, 16);
         else if (k == 1) begin
            ext_rst_n = 1'b0;
            cyc(5);
            ext_rst_n = 1'b1;
         end else begin
            uv = 1'b1;
            cyc(10);
            uv = 1'b0;
         end
         cyc(10);
         check_read(8'hFF, 8'hFF, "otemp clear");
      end
      // refused frames leave the register untouched
      frame(8'h00, 8'h00, 16);
      frame(INSTR_STATUS_WRITE, 8'h00, 12);
      check_read(8'hFF, 8'hFF, "refused frames");
      final_report();
   end
endmodule : tb_top
